// [hw/fpes_pkg.sv]
/*
  Constants for the flash program/erase sequencer: register map,
  field positions, reset values and timing counts.
  Assumes a 50 MHz system clock.
*/
package fpes_pkg;
  // ******************************************************************
  // Clock
  // ******************************************************************
  localparam int CLK_MHZ = 50;
  localparam int CLK_NS = 20;
  // ******************************************************************
  // Register map (byte addresses)
  // ******************************************************************
  localparam logic [11:0] ADDR_MODULE_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_ARRAY_CHECK = 12'h004;
  localparam logic [11:0] ADDR_WAIT_STATES = 12'h008;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;
  localparam logic [11:0] ADDR_TIMEOUT_US = 12'h014;
  // Module control fields
  localparam int MC_GO_BIT = 0;
  localparam int MC_DONE_BIT = 1;
  localparam int MC_ERASE_BIT = 2;
  localparam int MC_BLOCK_BIT = 3;
  localparam int MC_LOWPOWER_BIT = 4;
  localparam int MC_READY_BIT = 5;
  localparam int MC_TIMEOUT_BIT = 6;
  // Array check fields
  localparam int AC_ENABLE_BIT = 0;
  localparam int AC_DONE_BIT = 1;
  localparam int AC_SUSPEND_BIT = 2;
  localparam int AC_BPDIS_BIT = 3;
  localparam int AC_MARGIN_BIT = 4;
  localparam int AC_PROP_BIT = 5;
  localparam int AC_SIZE_LSB = 8;
  // Interrupt status fields
  localparam int IRQ_PE_DONE = 0;
  localparam int IRQ_AC_DONE = 1;
  localparam int IRQ_TIMEOUT = 2;
  localparam int IRQ_READY = 3;
  localparam int IRQ_W = 4;
  localparam logic [3:0] WS_RESET = 4'h1;
  // ******************************************************************
  // Timing (figures in their own unit, counts derived except AC_STOP_CYC and MR_STOP_CYC)
  // ******************************************************************
  localparam int ABORT_MIN_US = 5;
  localparam int ABORT_MAX_US = 22;
  localparam int ABORT_CYC = ABORT_MIN_US * 1000 / CLK_NS + 4;
  localparam int RECOVER_MIN_US = 14;
  localparam int RECOVER_MAX_US = 21;
  localparam int RECOVER_CYC = (RECOVER_MIN_US * 1000 + CLK_NS - 1) / CLK_NS + 7;
  localparam int AC_STOP_CYC = 50;
  localparam int MR_STOP_US = 26;
  localparam int MR_STOP_CYC = 15 + 2;
  localparam int MR_ADDER_US = 40;
  localparam int MR_ADDER_CYC = MR_ADDER_US * 1000 / CLK_NS;
  localparam int PGM_QP_MAX_US = 450;
  localparam int ERS_BLOCK_MAX_MS = 60;
  localparam int TIMEOUT_US_RESET = ERS_BLOCK_MAX_MS * 1000;
  localparam int US_CYC = 1000 / CLK_NS;
  localparam int SEQ_READS_256K = 8192;
  localparam int PROP_READS_256K = 106496;
  typedef enum logic [1:0] {
    FPES_BLK_256K, FPES_BLK_512K, FPES_BLK_1M, FPES_BLK_2M
  } fpes_blk_t;
endpackage

// [hw/fpes_delay.sv]
/*
  Restartable cycle counter that pulses once when a loaded count expires.
  Assumes one clock and synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fpes_delay #(
  parameter int W = 24
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [W-1:0] count,
  input wire logic cancel,
  output logic busy,
  output logic expired
);
  logic [W-1:0] cnt_reg;

  // Down counter; load takes priority over cancel
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_reg <= '0;
      busy <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (load) begin
        cnt_reg <= count;
        busy <= 1'b1;
      end else if (cancel) begin
        busy <= 1'b0;
      end else if (busy) begin
        if (cnt_reg <= W'(1)) begin
          busy <= 1'b0;
          expired <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - W'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// [hw/fpes_read_wait.sv]
/*
  Flash array read path: holds each read for the programmed wait states.
  Assumes the array presents data once addressed and holds it.
*/
`timescale 1ns/1ps
`default_nettype none
module fpes_read_wait (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [3:0] read_wait_states,
  input wire logic rd_req,
  input wire logic [31:0] array_rdata,
  output logic rd_valid,
  output logic [31:0] rd_data,
  output logic busy
);
  logic [3:0] ws_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ws_reg <= '0;
      busy <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 32'h0;
    end else begin
      rd_valid <= 1'b0;
      if (!busy && rd_req) begin
        busy <= 1'b1;
        ws_reg <= read_wait_states;
      end else if (busy) begin
        if (ws_reg == 4'h0) begin
          busy <= 1'b0;
          rd_valid <= 1'b1;
          rd_data <= array_rdata;
        end else begin
          ws_reg <= ws_reg - 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [hw/fpes_top.sv]
/*
  Flash program/erase sequencer: go/abort handshake, array checks with suspend and resume,
  low power recovery, operation timeout, wait states, APB slave and a level interrupt.
  Assumes an APB master on ref_clk; array busy levels are synchronised here.
*/
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fpes_top #(
  parameter int ABORT_CYCLES = fpes_pkg::ABORT_CYC,
  parameter int RECOVER_CYCLES = fpes_pkg::RECOVER_CYC,
  parameter int MR_ADDER_CYCLES = fpes_pkg::MR_ADDER_CYC,
  parameter int US_CYCLES = fpes_pkg::US_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic op_start,
  output logic op_abort,
  output logic check_start,
  output logic check_stop,
  input wire logic op_busy_i,
  input wire logic check_busy_i,
  input wire logic rd_req,
  input wire logic [31:0] array_rdata,
  output logic rd_valid,
  output logic [31:0] rd_data
);
  import fpes_pkg::*;

  // ******************************************************************
  // Registers
  // ******************************************************************
  logic go_reg, done_reg, erase_reg, block_reg, lowpower_reg, ready_reg, tmo_reg;
  logic en_reg, acdone_reg, sus_reg, bpdis_reg, margin_reg, prop_reg;
  logic [1:0] size_reg;
  logic [3:0] read_wait_states;
  logic [IRQ_W-1:0] stat_reg, mask_reg, ev;
  logic [15:0] tmo_us_reg;
  logic op_active, chk_active;
  logic op_b1, op_b2, op_b3, chk_b1, chk_b2, chk_b3;
  logic wr, rd;
  logic new_go, new_en, new_sus, new_bp;
  logic ab_busy, ab_exp, rc_busy, rc_exp, st_busy, st_exp, to_busy, to_exp;
  logic [5:0] us_div_reg;
  logic us_tick;
  logic [15:0] us_cnt_reg;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign new_go = pwdata[MC_GO_BIT];
  assign new_en = pwdata[AC_ENABLE_BIT];
  assign new_sus = pwdata[AC_SUSPEND_BIT];
  assign new_bp = pwdata[AC_BPDIS_BIT];

  // Busy crosses via two flops; a third keeps history for the fall
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      op_b1 <= 1'b0;
      op_b2 <= 1'b0;
      chk_b1 <= 1'b0;
      chk_b2 <= 1'b0;
      op_b3 <= 1'b0;
      chk_b3 <= 1'b0;
    end else begin
      op_b1 <= op_busy_i;
      op_b2 <= op_b1;
      op_b3 <= op_b2;
      chk_b1 <= check_busy_i;
      chk_b2 <= chk_b1;
      chk_b3 <= chk_b2;
    end
  end

  // ******************************************************************
  // Program/erase handshake
  // ******************************************************************
  wire go_rise = wr && paddr == ADDR_MODULE_CONTROL && new_go && !go_reg && ready_reg;
  wire go_fall = wr && paddr == ADDR_MODULE_CONTROL && !new_go && go_reg;
  wire op_complete = op_active && !ab_busy && !op_b2 && op_b3;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      go_reg <= 1'b0;
      done_reg <= 1'b1;
      op_active <= 1'b0;
      erase_reg <= 1'b0;
      block_reg <= 1'b0;
      lowpower_reg <= 1'b0;
      op_start <= 1'b0;
      op_abort <= 1'b0;
    end else begin
      op_start <= go_rise;
      op_abort <= go_fall && op_active;
      if (wr && paddr == ADDR_MODULE_CONTROL) begin
        go_reg <= new_go && (ready_reg || go_reg);
        lowpower_reg <= pwdata[MC_LOWPOWER_BIT];
        if (!op_active) begin
          erase_reg <= pwdata[MC_ERASE_BIT];
          block_reg <= pwdata[MC_BLOCK_BIT];
        end
      end
      if (go_rise) begin
        done_reg <= 1'b0;
        op_active <= 1'b1;
      end else if (ab_exp || op_complete || to_exp) begin
        done_reg <= 1'b1;
        op_active <= 1'b0;
      end
    end
  end
  fpes_delay #(.W(24)) u_abort (
    .ref_clk(ref_clk), .srst(srst),
    .load(go_fall && op_active), .count(24'(ABORT_CYCLES)),
    .cancel(go_rise), .busy(ab_busy), .expired(ab_exp)
  );

  // ******************************************************************
  // Microsecond tick and operation timeout
  // ******************************************************************
  // One-cycle enable each microsecond
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      us_div_reg <= '0;
      us_tick <= 1'b0;
    end else begin
      us_tick <= us_div_reg == 6'(US_CYCLES - 1);
      us_div_reg <= (us_div_reg == 6'(US_CYCLES - 1)) ? 6'h0 : us_div_reg + 6'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tmo_us_reg <= 16'(TIMEOUT_US_RESET);
    end else if (wr && paddr == ADDR_TIMEOUT_US) begin
      tmo_us_reg <= (pwdata[15:0] < 16'(PGM_QP_MAX_US)) ? 16'(PGM_QP_MAX_US) : pwdata[15:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      us_cnt_reg <= '0;
      to_busy <= 1'b0;
      to_exp <= 1'b0;
      tmo_reg <= 1'b0;
    end else begin
      to_exp <= 1'b0;
      if (go_rise) begin
        us_cnt_reg <= tmo_us_reg;
        to_busy <= 1'b1;
        tmo_reg <= 1'b0;
      end else if (!op_active || ab_busy) begin
        to_busy <= 1'b0;
      end else if (to_busy && us_tick) begin
        if (us_cnt_reg <= 16'h1) begin
          to_busy <= 1'b0;
          to_exp <= 1'b1;
          tmo_reg <= 1'b1;
        end else begin
          us_cnt_reg <= us_cnt_reg - 16'h1;
        end
      end
    end
  end

  // ******************************************************************
  // Low power recovery
  // ******************************************************************
  wire lp_exit = wr && paddr == ADDR_MODULE_CONTROL && lowpower_reg && !pwdata[MC_LOWPOWER_BIT];
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ready_reg <= 1'b1;
    end else if (wr && paddr == ADDR_MODULE_CONTROL && pwdata[MC_LOWPOWER_BIT]) begin
      ready_reg <= 1'b0;
    end else if (rc_exp) begin
      ready_reg <= 1'b1;
    end
  end

  fpes_delay #(.W(16)) u_recover (
    .ref_clk(ref_clk), .srst(srst),
    .load(lp_exit), .count(16'(RECOVER_CYCLES)),
    .cancel(1'b0), .busy(rc_busy), .expired(rc_exp)
  );

  // ******************************************************************
  // Array check: start, resume, abort, suspend
  // ******************************************************************
  wire ac_wr = wr && paddr == ADDR_ARRAY_CHECK;
  wire ac_start = ac_wr && new_en && !en_reg;
  wire ac_resume = ac_wr && en_reg && ((sus_reg && !new_sus) || (bpdis_reg && !new_bp));
  wire ac_stop = ac_wr && chk_active && ((en_reg && !new_en) || (!sus_reg && new_sus));
  wire ac_finish = chk_active && !st_busy && !chk_b2 && chk_b3;
  wire [23:0] stop_cyc = margin_reg ? 24'(MR_STOP_CYC) : 24'(AC_STOP_CYC - 4);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      en_reg <= 1'b0;
      sus_reg <= 1'b0;
      bpdis_reg <= 1'b0;
      margin_reg <= 1'b0;
      prop_reg <= 1'b0;
      size_reg <= 2'h0;
      acdone_reg <= 1'b1;
      chk_active <= 1'b0;
      check_start <= 1'b0;
      check_stop <= 1'b0;
    end else begin
      check_start <= ac_start || ac_resume;
      check_stop <= ac_stop;
      if (ac_wr) begin
        en_reg <= new_en;
        sus_reg <= new_sus;
        bpdis_reg <= new_bp;
        if (!chk_active) begin
          margin_reg <= pwdata[AC_MARGIN_BIT];
          prop_reg <= pwdata[AC_PROP_BIT];
          size_reg <= pwdata[AC_SIZE_LSB +: 2];
        end
      end
      if (ac_start || ac_resume) begin
        acdone_reg <= 1'b0;
        chk_active <= 1'b1;
      end else if (st_exp || ac_finish) begin
        acdone_reg <= 1'b1;
        chk_active <= 1'b0;
      end
    end
  end

  fpes_delay #(.W(24)) u_stop (
    .ref_clk(ref_clk), .srst(srst),
    .load(ac_stop), .count(stop_cyc),
    .cancel(ac_start || ac_resume), .busy(st_busy), .expired(st_exp)
  );

  // ******************************************************************
  // Read path
  // ******************************************************************
  // reads stretched by wait states
  fpes_read_wait u_read (
    .ref_clk(ref_clk), .srst(srst),
    .read_wait_states(read_wait_states), .rd_req(rd_req),
    .array_rdata(array_rdata), .rd_valid(rd_valid), .rd_data(rd_data),
    .busy()
  );

  // field holds settings up to fifteen
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      read_wait_states <= WS_RESET;
    end else if (wr && paddr == ADDR_WAIT_STATES) begin
      read_wait_states <= pwdata[3:0];
    end
  end

  // ******************************************************************
  // Interrupts: sticky status, read clears, set wins
  // ******************************************************************
  assign ev = {rc_exp, to_exp, (st_exp || ac_finish), (ab_exp || op_complete || to_exp)};

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stat_reg <= '0;
      mask_reg <= '0;
      irq <= 1'b0;
    end else begin
      stat_reg <= ((rd && paddr == ADDR_IRQ_STATUS) ? '0 : stat_reg) | ev;
      if (wr && paddr == ADDR_IRQ_MASK) begin
        mask_reg <= pwdata[IRQ_W-1:0];
      end
      irq <= |((((rd && paddr == ADDR_IRQ_STATUS) ? '0 : stat_reg) | ev) & mask_reg);
    end
  end

  // ******************************************************************
  // APB slave: zero wait states, error on unmapped address
  // ******************************************************************
  logic [31:0] rdata_next;
  logic hit;
  // Read mux
  always_comb begin
    rdata_next = 32'h0;
    hit = 1'b1;
    case (paddr)
      ADDR_MODULE_CONTROL: rdata_next = 32'({tmo_reg, ready_reg, lowpower_reg, block_reg,
                                              erase_reg, done_reg, go_reg});
      ADDR_ARRAY_CHECK: rdata_next = {22'h0, size_reg, 2'h0, prop_reg, margin_reg,
                                      bpdis_reg, sus_reg, acdone_reg, en_reg};
      ADDR_WAIT_STATES: rdata_next = {28'h0, read_wait_states};
      ADDR_IRQ_STATUS: rdata_next = 32'(stat_reg);
      ADDR_IRQ_MASK: rdata_next = 32'(mask_reg);
      ADDR_TIMEOUT_US: rdata_next = {16'h0, tmo_us_reg};
      default: hit = 1'b0;
    endcase
  end

  // Answer in the setup cycle's following edge so access sees pready high
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (psel && !penable && !pwrite) begin
        prdata <= rdata_next;
      end
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  done_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
    go_rise |=> !done_reg && op_active) else $error("done not cleared on start");
  abort_time_a: assert property (@(posedge ref_clk) disable iff (srst)
    (go_fall && op_active) |=> !done_reg [*8]) else $error("abort done too early");
  recover_a: assert property (@(posedge ref_clk) disable iff (srst)
    lp_exit |=> !ready_reg [*8]) else $error("ready before recovery");
  chk_start_a: assert property (@(posedge ref_clk) disable iff (srst)
    ac_start |=> !acdone_reg) else $error("check done not cleared");
  chk_resume_a: assert property (@(posedge ref_clk) disable iff (srst)
    ac_resume |=> !acdone_reg && chk_active) else $error("resume did not clear done");
  ai_stop_a: assert property (@(posedge ref_clk) disable iff (srst)
    (ac_stop && !margin_reg) |-> ##[1:50] acdone_reg) else $error("integrity stop late");
  mr_stop_a: assert property (@(posedge ref_clk) disable iff (srst)
    (ac_stop && margin_reg) |-> ##[1:40] acdone_reg) else $error("margin stop late");
  tmo_floor_a: assert property (@(posedge ref_clk) disable iff (srst)
    tmo_us_reg >= 16'(PGM_QP_MAX_US)) else $error("timeout below program time");
  op_cov: cover property (@(posedge ref_clk) go_rise ##[1:1000] ab_exp);
  chk_cov: cover property (@(posedge ref_clk) ac_start ##[1:1000] st_exp);
  lp_cov: cover property (@(posedge ref_clk) lp_exit ##[1:1000] rc_exp);
endmodule
`default_nettype wire

// [testbench/fpes_flash_model.sv]
/*
  Flash array partner model: busy levels for operations and checks,
  read data held while addressed.
  Assumes start, abort and stop pulses from the sequencer on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module fpes_flash_model #(
  parameter int OP_LEN = 3000,
  parameter int CK_LEN = 3000
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic fast,
  input wire logic op_start,
  input wire logic op_abort,
  input wire logic check_start,
  input wire logic check_stop,
  input wire logic rd_req,
  input wire logic [31:0] data_in,
  output logic op_busy,
  output logic check_busy,
  output logic [31:0] rdata
);
  int op_cnt;
  int ck_cnt;
  int rd_cnt;
  // ****************
  // Busy timers
  // ****************
  // bounded operation time
  always_ff @(posedge ref_clk) begin
    if (srst || op_abort)
      op_cnt <= 0;
    else if (op_start)
      op_cnt <= fast ? 20 : OP_LEN;
    else if (op_cnt > 0)
      op_cnt <= op_cnt - 1;
  end
  always_ff @(posedge ref_clk) begin
    if (srst || check_stop)
      ck_cnt <= 0;
    else if (check_start)
      ck_cnt <= CK_LEN;
    else if (ck_cnt > 0)
      ck_cnt <= ck_cnt - 1;
  end
  assign op_busy = op_cnt > 0;
  assign check_busy = ck_cnt > 0;
  // Data held while addressed, scrambled otherwise so stale reads show
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_cnt <= 0;
      rdata <= 32'h5a5a0f0f;
    end else if (rd_req) begin
      rd_cnt <= 20;
      rdata <= data_in;
    end else if (rd_cnt > 0)
      rd_cnt <= rd_cnt - 1;
    else
      rdata <= ~rdata;
  end
endmodule
`default_nettype wire

// [testbench/fpes_bench.sv]
/*
  Self-checking bench for the flash sequencer: APB master, array model.
  Assumes shortened abort and recovery counts.
*/
`timescale 1ns/1ps
`default_nettype none
module fpes_bench;
  import fpes_pkg::*;
  localparam int ABT = 10;
  localparam int RCV = 10;
  logic ref_clk, srst, psel, penable, pwrite, rd_req, fast, es;
  logic op_busy_i, check_busy_i, pready, pslverr, irq, rd_valid;
  logic op_start, op_abort, check_start, check_stop;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, array_rdata, rd_data, data_in, rv;
  logic [15:0] seed;
  int num_errors, tests_run, n, base, ws;
  fpes_top #(.ABORT_CYCLES(ABT), .RECOVER_CYCLES(RCV)) dut (.ref_clk(ref_clk),
    .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .op_start(op_start), .op_abort(op_abort), .check_start(check_start),
    .check_stop(check_stop), .op_busy_i(op_busy_i), .check_busy_i(check_busy_i),
    .rd_req(rd_req), .array_rdata(array_rdata), .rd_valid(rd_valid), .rd_data(rd_data));
  fpes_flash_model flash (.ref_clk(ref_clk), .srst(srst), .fast(fast),
    .op_start(op_start), .op_abort(op_abort), .check_start(check_start),
    .check_stop(check_stop), .rd_req(rd_req), .data_in(data_in),
    .op_busy(op_busy_i), .check_busy(check_busy_i), .rdata(array_rdata));
  // ****************
  // Helpers
  // ****************
  // Fibonacci step, fixed seed keeps runs repeatable
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16)
      chk("pready", 1, 0);
    rv = prdata;
    es = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rbit(input string nm, input logic [11:0] a, input int b, input logic e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rv[b]);
  endtask
  // Cycles from read request to valid data
  task automatic rd_lat(output int c);
    @(posedge ref_clk);
    rd_req <= 1'b1;
    @(posedge ref_clk);
    rd_req <= 1'b0;
    c = 1;
    while (rd_valid !== 1'b1 && c < 40) begin
      @(posedge ref_clk);
      c++;
    end
  endtask
  task automatic report_and_stop;
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ****************
  // Clock, watchdog, sequence
  // ****************
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #400000;
    num_errors++;
    report_and_stop;
  end
  initial begin
    {psel, penable, pwrite, rd_req, fast} = '0;
    paddr = '0;
    pwdata = '0;
    data_in = '0;
    seed = 16'hbae6;
    srst = 1'b1;
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    apb(1'b0, ADDR_MODULE_CONTROL, 0);
    chk("ctrl_rst", 32'h22, rv);
    apb(1'b0, ADDR_ARRAY_CHECK, 0);
    chk("check_rst", 32'h2, rv);
    apb(1'b0, ADDR_WAIT_STATES, 0);
    chk("ws_rst", 32'h1, rv);
    apb(1'b0, ADDR_TIMEOUT_US, 0);
    chk("tmo_rst", 32'h0000ea60, rv);
    apb(1'b0, 12'h020, 0);
    chk("slverr", 1, es);
    wr(ADDR_MODULE_CONTROL, 32'h1);
    rbit("go_done", ADDR_MODULE_CONTROL, MC_DONE_BIT, 0);
    wr(ADDR_MODULE_CONTROL, 32'h0);
    rbit("abort_early", ADDR_MODULE_CONTROL, MC_DONE_BIT, 0);
    repeat (ABT) @(posedge ref_clk);
    rbit("abort_done", ADDR_MODULE_CONTROL, MC_DONE_BIT, 1);
    chk("irq_masked", 0, irq);
    wr(ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk("irq_on", 1, irq);
    rbit("irq_stat", ADDR_IRQ_STATUS, IRQ_PE_DONE, 1);
    repeat (2) @(posedge ref_clk);
    chk("irq_off", 0, irq);
    wr(ADDR_MODULE_CONTROL, 32'hd);
    wr(ADDR_MODULE_CONTROL, 32'hc);
    repeat (3 * ABT) @(posedge ref_clk);
    rbit("blk_abort", ADDR_MODULE_CONTROL, MC_DONE_BIT, 1);
    wr(ADDR_MODULE_CONTROL, 32'h0);
    fast <= 1'b1;
    wr(ADDR_MODULE_CONTROL, 32'h1);
    repeat (30) @(posedge ref_clk);
    rbit("op_end", ADDR_MODULE_CONTROL, MC_DONE_BIT, 1);
    chk("irq_end", 1, irq);
    wr(ADDR_MODULE_CONTROL, 32'h0);
    fast <= 1'b0;
    wr(ADDR_TIMEOUT_US, 32'd100);
    apb(1'b0, ADDR_TIMEOUT_US, 0);
    chk("tmo_clamp", 32'd450, rv);
    wr(ADDR_ARRAY_CHECK, 32'h1);
    rbit("ck_start", ADDR_ARRAY_CHECK, AC_DONE_BIT, 0);
    wr(ADDR_ARRAY_CHECK, 32'h0);
    repeat (AC_STOP_CYC - 2) @(posedge ref_clk);
    rbit("ck_abort", ADDR_ARRAY_CHECK, AC_DONE_BIT, 1);
    wr(ADDR_ARRAY_CHECK, 32'h1);
    wr(ADDR_ARRAY_CHECK, 32'h5);
    repeat (AC_STOP_CYC - 2) @(posedge ref_clk);
    rbit("ck_susp", ADDR_ARRAY_CHECK, AC_DONE_BIT, 1);
    wr(ADDR_ARRAY_CHECK, 32'h1);
    rbit("ck_resume", ADDR_ARRAY_CHECK, AC_DONE_BIT, 0);
    wr(ADDR_ARRAY_CHECK, 32'h0);
    repeat (AC_STOP_CYC) @(posedge ref_clk);
    wr(ADDR_ARRAY_CHECK, 32'h11);
    wr(ADDR_ARRAY_CHECK, 32'h10);
    repeat (MR_STOP_US * US_CYC) @(posedge ref_clk);
    rbit("mr_stop", ADDR_ARRAY_CHECK, AC_DONE_BIT, 1);
    wr(ADDR_MODULE_CONTROL, 32'h10);
    rbit("lp_rdy", ADDR_MODULE_CONTROL, MC_READY_BIT, 0);
    wr(ADDR_MODULE_CONTROL, 32'h0);
    rbit("rcv_early", ADDR_MODULE_CONTROL, MC_READY_BIT, 0);
    repeat (RCV) @(posedge ref_clk);
    rbit("rcv_done", ADDR_MODULE_CONTROL, MC_READY_BIT, 1);
    wr(ADDR_WAIT_STATES, 32'h1);
    rd_lat(base);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      ws = 1 + int'(seed[2:0]);
      data_in <= {seed, ~seed};
      wr(ADDR_WAIT_STATES, 32'(ws));
      apb(1'b0, ADDR_WAIT_STATES, 0);
      chk("ws_rd", 32'(ws), rv);
      rd_lat(n);
      chk("rd_lat", 32'(base + ws - 1), 32'(n));
      chk("rd_data", data_in, rd_data);
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
